// *** hdl/pnr_pkg.sv ***
// Command codes, field layouts, reset values and helpers for the non-overlap and rail order bank.
package pnr_pkg;

  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int ID_W   = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Command codes.
  localparam logic [7:0] CMD_EXT_TEMP_GAIN  = 8'hD9;
  localparam logic [7:0] CMD_EXT_TEMP_BIAS  = 8'hDA;
  localparam logic [7:0] CMD_OUTPUT_CEILING = 8'hDB;
  localparam logic [7:0] CMD_SENSE_TEMPCO   = 8'hDC;
  localparam logic [7:0] CMD_NOVL_VALUES    = 8'hDD;
  localparam logic [7:0] CMD_NOVL_MODE      = 8'hDE;
  localparam logic [7:0] CMD_RAIL_ORDER     = 8'hE0;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int NOVL_HL_MSB        = 15;
  localparam int NOVL_HL_LSB        = 8;
  localparam int NOVL_LH_MSB        = 7;
  localparam int NOVL_LH_LSB        = 0;
  localparam int MODE_HL_FREEZE_BIT = 15;
  localparam int MODE_HL_MIN_MSB    = 14;
  localparam int MODE_HL_MIN_LSB    = 8;
  localparam int MODE_LH_FREEZE_BIT = 7;
  localparam int MODE_LH_MIN_MSB    = 6;
  localparam int MODE_LH_MIN_LSB    = 0;
  localparam int ORDER_PREV_EN_BIT  = 15;
  localparam int ORDER_PREV_ID_MSB  = 12;
  localparam int ORDER_PREV_ID_LSB  = 8;
  localparam int ORDER_NEXT_EN_BIT  = 7;
  localparam int ORDER_NEXT_ID_MSB  = 4;
  localparam int ORDER_NEXT_ID_LSB  = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and limits, in nanoseconds where signed.
  localparam logic [15:0]        RST_EXT_TEMP_GAIN = 16'h0000;
  localparam logic [15:0]        RST_EXT_TEMP_BIAS = 16'h0000;
  localparam logic [7:0]         RST_SENSE_TEMPCO  = 8'h00;
  localparam logic [15:0]        RST_NOVL_VALUES   = 16'h3C3C;
  localparam logic [15:0]        RST_NOVL_MODE     = 16'h0000;
  localparam logic [15:0]        RST_RAIL_ORDER    = 16'h0000;
  localparam logic signed [7:0]  NOVL_LOW_NS       = -8'sd10;
  localparam logic signed [7:0]  NOVL_HIGH_NS      = 8'sd60;
  localparam logic signed [7:0]  NOVL_DEF_MAX_NS   = 8'sd60;

  // True when a signed non-overlap byte lies inside the legal span.
  function automatic logic novl_in_range(input logic signed [7:0] v);
    return (v >= NOVL_LOW_NS) && (v <= NOVL_HIGH_NS);
  endfunction

endpackage

// *** hdl/pnr_strap_sync.sv ***
// Strap pin synchroniser that holds a value once two late stages agree.
`timescale 1ns/1ps
module pnr_strap_sync #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] level_ff;

  if (W < 1) begin : g_bad_width
    $error("Strap width must be at least one bit.");
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level_ff <= '0;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign level = level_ff;

  a_strap_agree: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$stable(level_ff) |-> $past(s2_ff) == $past(s3_ff) && level_ff == $past(s3_ff))
    else $error("Strap level changed without agreement.");

endmodule

// *** hdl/pnr_novl_adapt.sv ***
// Adaptive non-overlap tracker for one switching direction.
`timescale 1ns/1ps
module pnr_novl_adapt #(
  parameter int W = 8
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                adaptive,
  input  wire logic                step_down,
  input  wire logic                step_up,
  input  wire logic signed [W-1:0] min_ns,
  input  wire logic signed [W-1:0] max_ns,
  input  wire logic signed [W-1:0] fixed_ns,
  output logic signed      [W-1:0] work_ns,
  output logic                     gap,
  output logic                     overlap
);
  import pnr_pkg::*;

  logic signed [W-1:0] work_ff;
  logic signed [W-1:0] nxt_work;
  logic signed [W:0]   stepped;
  logic                gap_ff;
  logic                overlap_ff;

  if (W < 8) begin : g_bad_width
    $error("Non-overlap width must hold a signed byte.");
  end

  // Upper bound first, lower bound last, so the floor wins on a crossed pair.
  function automatic logic signed [W:0] clamp(input logic signed [W:0] v,
                                              input logic signed [W-1:0] lo,
                                              input logic signed [W-1:0] hi);
    logic signed [W:0] r;
    r = v;
    if (r > W'(hi)) r = (W+1)'(hi);
    if (r < W'(lo)) r = (W+1)'(lo);
    return r;
  endfunction

  always_comb begin
    stepped  = (W+1)'(work_ff);
    if (step_up && !step_down) stepped = stepped + (W+1)'(1);
    if (step_down && !step_up) stepped = stepped - (W+1)'(1);
    if (adaptive) begin
      nxt_work = W'(clamp(stepped, min_ns, max_ns));
    end else begin
      nxt_work = fixed_ns;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      work_ff    <= W'(NOVL_DEF_MAX_NS);
      gap_ff     <= 1'b1;
      overlap_ff <= 1'b0;
    end else begin
      work_ff    <= nxt_work;
      gap_ff     <= nxt_work > 0;
      overlap_ff <= nxt_work < 0;
    end
  end

  assign work_ns = work_ff;
  assign gap     = gap_ff;
  assign overlap = overlap_ff;

  a_work_bounded: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(adaptive) && $stable(min_ns) && $stable(max_ns) && min_ns <= max_ns
    |-> work_ns >= $past(min_ns) && work_ns <= $past(max_ns))
    else $error("Adaptive non-overlap left its bounds.");

  a_sign_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    (work_ns > 0 |-> gap && !overlap) and (work_ns < 0 |-> overlap && !gap))
    else $error("Gap and overlap flags disagree with the sign.");

endmodule

// *** hdl/pnr_nonoverlap_bank.sv ***
// Command-level register bank for switch non-overlap, sensing trim and rail order links.
`timescale 1ns/1ps
module pnr_nonoverlap_bank (
  input  wire logic                               core_clk,
  input  wire logic                               rst_n,
  input  wire logic                               cmd_valid,
  input  wire logic                               cmd_write,
  input  wire logic                               cmd_is_word,
  input  wire logic [7:0]                         cmd_code,
  input  wire logic [pnr_pkg::WORD_W-1:0]         cmd_wdata,
  output logic      [pnr_pkg::WORD_W-1:0]         cmd_rdata,
  output logic                                    cmd_ack,
  output logic                                    cmd_error,
  input  wire logic [pnr_pkg::WORD_W-1:0]         strap_vout_ceiling,
  input  wire logic                               hl_shorter,
  input  wire logic                               hl_longer,
  input  wire logic                               lh_shorter,
  input  wire logic                               lh_longer,
  output logic signed [pnr_pkg::BYTE_W-1:0]       novl_hl_ns,
  output logic signed [pnr_pkg::BYTE_W-1:0]       novl_lh_ns,
  output logic                                    hl_gap,
  output logic                                    hl_overlap,
  output logic                                    lh_gap,
  output logic                                    lh_overlap,
  output logic                                    hl_adaptive,
  output logic                                    lh_adaptive,
  output logic                                    prev_rail_en,
  output logic      [pnr_pkg::ID_W-1:0]           prev_rail_group_id,
  output logic                                    next_rail_en,
  output logic      [pnr_pkg::ID_W-1:0]           next_rail_group_id,
  output logic      [pnr_pkg::BYTE_W-1:0]         sense_tempco_factor
);
  import pnr_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [WORD_W-1:0]        ext_temp_gain_ff;
  logic [WORD_W-1:0]        ext_temp_bias_ff;
  logic [BYTE_W-1:0]        sense_tempco_factor_ff;
  logic [WORD_W-1:0]        novl_values_ff;
  logic [WORD_W-1:0]        novl_mode_ff;
  logic [WORD_W-1:0]        rail_order_ff;
  logic signed [BYTE_W-1:0] max_hl_ff;
  logic signed [BYTE_W-1:0] max_lh_ff;
  logic                     novl_wr_last_ff;
  logic [WORD_W-1:0]        cmd_rdata_ff;
  logic                     cmd_ack_ff;
  logic                     cmd_error_ff;

  logic [WORD_W-1:0]        ceiling_level;
  logic [WORD_W-1:0]        nxt_rdata;
  logic                     hit;
  logic                     writable;
  logic                     want_word;
  logic                     bad_value;
  logic                     cmd_bad;
  logic                     wr_ok;
  logic                     wr_gain;
  logic                     wr_bias;
  logic                     wr_tempco;
  logic                     wr_values;
  logic                     wr_mode;
  logic                     wr_order;
  logic signed [BYTE_W-1:0] min_hl_ns;
  logic signed [BYTE_W-1:0] min_lh_ns;
  logic signed [BYTE_W-1:0] fix_hl_ns;
  logic signed [BYTE_W-1:0] fix_lh_ns;

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture for the read-only ceiling.
  pnr_strap_sync #(
    .W (WORD_W)
  ) u_ceiling_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (strap_vout_ceiling),
    .level    (ceiling_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Command decode.
  always_comb begin
    hit       = 1'b0;
    writable  = 1'b1;
    want_word = 1'b1;
    nxt_rdata = '0;
    if (cmd_code == CMD_EXT_TEMP_GAIN) begin
      hit       = 1'b1;
      nxt_rdata = ext_temp_gain_ff;
    end else if (cmd_code == CMD_EXT_TEMP_BIAS) begin
      hit       = 1'b1;
      nxt_rdata = ext_temp_bias_ff;
    end else if (cmd_code == CMD_OUTPUT_CEILING) begin
      hit       = 1'b1;
      writable  = 1'b0;
      nxt_rdata = ceiling_level;
    end else if (cmd_code == CMD_SENSE_TEMPCO) begin
      hit       = 1'b1;
      want_word = 1'b0;
      nxt_rdata = {8'h00, sense_tempco_factor_ff};
    end else if (cmd_code == CMD_NOVL_VALUES) begin
      hit       = 1'b1;
      nxt_rdata = novl_values_ff;
    end else if (cmd_code == CMD_NOVL_MODE) begin
      hit       = 1'b1;
      nxt_rdata = novl_mode_ff;
    end else if (cmd_code == CMD_RAIL_ORDER) begin
      hit       = 1'b1;
      nxt_rdata = rail_order_ff;
    end
  end

  // Out-of-span non-overlap writes are refused whole.
  assign bad_value = cmd_write && (cmd_code == CMD_NOVL_VALUES) &&
                     !(novl_in_range(cmd_wdata[NOVL_HL_MSB:NOVL_HL_LSB]) &&
                       novl_in_range(cmd_wdata[NOVL_LH_MSB:NOVL_LH_LSB]));
  assign cmd_bad   = !hit || (cmd_write && !writable) || (cmd_is_word != want_word) ||
                     bad_value;
  assign wr_ok     = cmd_valid && cmd_write && !cmd_bad;
  assign wr_gain   = wr_ok && (cmd_code == CMD_EXT_TEMP_GAIN);
  assign wr_bias   = wr_ok && (cmd_code == CMD_EXT_TEMP_BIAS);
  assign wr_tempco = wr_ok && (cmd_code == CMD_SENSE_TEMPCO);
  assign wr_values = wr_ok && (cmd_code == CMD_NOVL_VALUES);
  assign wr_mode   = wr_ok && (cmd_code == CMD_NOVL_MODE);
  assign wr_order  = wr_ok && (cmd_code == CMD_RAIL_ORDER);

  //////////////////////////////////////////////////////////////////////////////
  // Answer path.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_ack_ff   <= 1'b0;
      cmd_error_ff <= 1'b0;
      cmd_rdata_ff <= '0;
    end else begin
      cmd_ack_ff   <= cmd_valid;
      cmd_error_ff <= cmd_valid && cmd_bad;
      if (cmd_valid && !cmd_write && !cmd_bad) begin
        cmd_rdata_ff <= nxt_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Temperature calibration words, kept for readback only, and the tempco byte that also drives sense_tempco_factor.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_temp_gain_ff <= RST_EXT_TEMP_GAIN;
      ext_temp_bias_ff <= RST_EXT_TEMP_BIAS;
    end else begin
      if (wr_gain) ext_temp_gain_ff <= cmd_wdata;
      if (wr_bias) ext_temp_bias_ff <= cmd_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sense_tempco_factor_ff <= RST_SENSE_TEMPCO;
    end else if (wr_tempco) begin
      sense_tempco_factor_ff <= cmd_wdata[BYTE_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Non-overlap values, mode and adaptive maxima.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      novl_values_ff <= RST_NOVL_VALUES;
      novl_mode_ff   <= RST_NOVL_MODE;
    end else begin
      if (wr_values) novl_values_ff <= cmd_wdata;
      if (wr_mode) novl_mode_ff <= cmd_wdata;
    end
  end

  // Any command other than a values write breaks the values-then-mode pairing.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      novl_wr_last_ff <= 1'b0;
    end else if (cmd_valid) begin
      novl_wr_last_ff <= wr_values;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      max_hl_ff <= NOVL_DEF_MAX_NS;
      max_lh_ff <= NOVL_DEF_MAX_NS;
    end else if (wr_mode && novl_wr_last_ff) begin
      max_hl_ff <= novl_values_ff[NOVL_HL_MSB:NOVL_HL_LSB];
      max_lh_ff <= novl_values_ff[NOVL_LH_MSB:NOVL_LH_LSB];
    end
  end

  assign min_hl_ns   = {novl_mode_ff[MODE_HL_MIN_MSB:MODE_HL_MIN_LSB], 1'b0};
  assign min_lh_ns   = {novl_mode_ff[MODE_LH_MIN_MSB:MODE_LH_MIN_LSB], 1'b0};
  assign fix_hl_ns   = novl_values_ff[NOVL_HL_MSB:NOVL_HL_LSB];
  assign fix_lh_ns   = novl_values_ff[NOVL_LH_MSB:NOVL_LH_LSB];
  assign hl_adaptive = !novl_mode_ff[MODE_HL_FREEZE_BIT];
  assign lh_adaptive = !novl_mode_ff[MODE_LH_FREEZE_BIT];

  pnr_novl_adapt #(
    .W (BYTE_W)
  ) u_adapt_hl (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .adaptive  (hl_adaptive),
    .step_down (hl_shorter),
    .step_up   (hl_longer),
    .min_ns    (min_hl_ns),
    .max_ns    (max_hl_ff),
    .fixed_ns  (fix_hl_ns),
    .work_ns   (novl_hl_ns),
    .gap       (hl_gap),
    .overlap   (hl_overlap)
  );

  pnr_novl_adapt #(
    .W (BYTE_W)
  ) u_adapt_lh (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .adaptive  (lh_adaptive),
    .step_down (lh_shorter),
    .step_up   (lh_longer),
    .min_ns    (min_lh_ns),
    .max_ns    (max_lh_ff),
    .fixed_ns  (fix_lh_ns),
    .work_ns   (novl_lh_ns),
    .gap       (lh_gap),
    .overlap   (lh_overlap)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Rail order links.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rail_order_ff <= RST_RAIL_ORDER;
    end else if (wr_order) begin
      rail_order_ff <= cmd_wdata;
    end
  end

  assign prev_rail_en        = rail_order_ff[ORDER_PREV_EN_BIT];
  assign prev_rail_group_id  = rail_order_ff[ORDER_PREV_ID_MSB:ORDER_PREV_ID_LSB];
  assign next_rail_en        = rail_order_ff[ORDER_NEXT_EN_BIT];
  assign next_rail_group_id  = rail_order_ff[ORDER_NEXT_ID_MSB:ORDER_NEXT_ID_LSB];
  assign sense_tempco_factor = sense_tempco_factor_ff;
  assign cmd_rdata           = cmd_rdata_ff;
  assign cmd_ack             = cmd_ack_ff;
  assign cmd_error           = cmd_error_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_gain_readback: assert property (
    cmd_valid && cmd_write && cmd_is_word && cmd_code == CMD_EXT_TEMP_GAIN ##1 !cmd_valid ##1
    cmd_valid && !cmd_write && cmd_is_word && cmd_code == CMD_EXT_TEMP_GAIN
    |=> cmd_ack && !cmd_error && cmd_rdata == $past(cmd_wdata, 3))
    else $error("Gain word did not read back.");

  a_bias_readback: assert property (
    cmd_valid && cmd_write && cmd_is_word && cmd_code == CMD_EXT_TEMP_BIAS ##1 !cmd_valid ##1
    cmd_valid && !cmd_write && cmd_is_word && cmd_code == CMD_EXT_TEMP_BIAS
    |=> cmd_rdata == $past(cmd_wdata, 3))
    else $error("Bias word did not read back.");

  a_ceiling_readonly: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_OUTPUT_CEILING |=> cmd_ack && cmd_error)
    else $error("Write to the ceiling was not refused.");

  a_ceiling_read: assert property (
    cmd_valid && !cmd_write && cmd_is_word && cmd_code == CMD_OUTPUT_CEILING
    |=> !cmd_error && cmd_rdata == $past(ceiling_level))
    else $error("Ceiling read returned the wrong value.");

  a_tempco_write: assert property (
    cmd_valid && cmd_write && !cmd_is_word && cmd_code == CMD_SENSE_TEMPCO
    |=> sense_tempco_factor == $past(cmd_wdata[7:0]))
    else $error("Tempco byte was not stored.");

  a_value_refused: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_NOVL_VALUES &&
    ($signed(cmd_wdata[15:8]) > 8'sd60 || $signed(cmd_wdata[15:8]) < -8'sd10)
    |=> cmd_error && $stable(novl_values_ff))
    else $error("Out-of-span high-to-low value was accepted.");

  a_value_low_refused: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_NOVL_VALUES &&
    ($signed(cmd_wdata[7:0]) > 8'sd60 || $signed(cmd_wdata[7:0]) < -8'sd10)
    |=> cmd_error && $stable(novl_values_ff))
    else $error("Out-of-span low-to-high value was accepted.");

  a_default_max: assert property (
    $rose(rst_n) |-> max_hl_ff == 8'sd60 && max_lh_ff == 8'sd60)
    else $error("Adaptive maxima did not default to sixty.");

  a_max_capture: assert property (
    wr_values ##1 wr_mode |=> max_hl_ff == novl_values_ff[15:8] &&
                               max_lh_ff == novl_values_ff[7:0])
    else $error("Maxima were not taken from the preceding values write.");

  a_max_capture_gap: assert property (
    wr_values ##1 !cmd_valid ##1 wr_mode |=> max_hl_ff == $past(cmd_wdata[15:8], 3) &&
                                             max_lh_ff == $past(cmd_wdata[7:0], 3))
    else $error("Maxima were not taken across an idle cycle.");

  a_max_kept: assert property (
    !(wr_mode && novl_wr_last_ff) |=> $stable(max_hl_ff) && $stable(max_lh_ff))
    else $error("Maxima changed without a paired write.");

  a_frozen_hl: assert property (
    novl_mode_ff[15] |=> novl_hl_ns == $past(novl_values_ff[15:8]))
    else $error("Frozen high-to-low value differs from the written one.");

  a_frozen_lh: assert property (
    novl_mode_ff[7] |=> novl_lh_ns == $past(novl_values_ff[7:0]))
    else $error("Frozen low-to-high value differs from the written one.");

  a_floor_hl: assert property (
    $past(hl_adaptive) && $stable(novl_mode_ff) |-> novl_hl_ns >= 2 * $signed(novl_mode_ff[14:8]))
    else $error("High-to-low value fell below its floor.");

  a_floor_lh: assert property (
    $past(lh_adaptive) && $stable(novl_mode_ff) |-> novl_lh_ns >= 2 * $signed(novl_mode_ff[6:0]))
    else $error("Low-to-high value fell below its floor.");

  a_order_prev: assert property (
    cmd_valid && cmd_write && cmd_is_word && cmd_code == CMD_RAIL_ORDER
    |=> prev_rail_en == $past(cmd_wdata[15]) && prev_rail_group_id == $past(cmd_wdata[12:8]))
    else $error("Preceding rail link was not stored.");

  a_order_next: assert property (
    cmd_valid && cmd_write && cmd_is_word && cmd_code == CMD_RAIL_ORDER
    |=> next_rail_en == $past(cmd_wdata[7]) && next_rail_group_id == $past(cmd_wdata[4:0]))
    else $error("Following rail link was not stored.");

endmodule

// *** dv/pnr_host_model.sv ***
// Host model that issues single commands on the bank's command port.
`timescale 1ns/1ps
module pnr_host_model
  import pnr_pkg::*;
(
  input  wire logic        core_clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic             cmd_is_word,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_error,
  input  wire logic [15:0] cmd_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_is_word = 1'b1;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Sends one command, scrambles the idle lines, waits a bounded time for ack.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic ok, output logic err, output logic [15:0] rd);
    ok = 1'b0;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_is_word = (c != CMD_SENSE_TEMPCO);
    cmd_wdata = d;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge core_clk);
      #1;
      if (i == 0) begin
        cmd_valid = 1'b0;
        cmd_write = ~w;
        cmd_code = ~c;
        cmd_wdata = ~d;
      end
      ok = (cmd_ack === 1'b1);
    end
    err = cmd_error;
    rd = cmd_rdata;
  endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the non-overlap and rail order bank.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb;
  import pnr_pkg::*;
  logic              core_clk, rst_n, cmd_valid, cmd_write, cmd_is_word, cmd_ack, cmd_error;
  logic [7:0]        cmd_code, sense_tempco_factor;
  logic [15:0]       cmd_wdata, cmd_rdata, strap_vout_ceiling, rd;
  logic              hl_shorter, hl_longer, lh_shorter, lh_longer, er;
  logic signed [7:0] novl_hl_ns, novl_lh_ns;
  logic              hl_gap, hl_overlap, lh_gap, lh_overlap, hl_adaptive, lh_adaptive;
  logic              prev_rail_en, next_rail_en;
  logic [4:0]        prev_rail_group_id, next_rail_group_id;
  int                bad_count = 0;
  int                checks_done = 0;
  logic [7:0]        rc [6] = '{8'hD9, 8'hDA, 8'hDC, 8'hDD, 8'hDE, 8'hE0};
  logic [15:0]       rv [6] = '{RST_EXT_TEMP_GAIN, RST_EXT_TEMP_BIAS, {8'h00, RST_SENSE_TEMPCO},
                                RST_NOVL_VALUES, RST_NOVL_MODE, RST_RAIL_ORDER};

  pnr_nonoverlap_bank dut (.core_clk, .rst_n, .cmd_valid, .cmd_write, .cmd_is_word, .cmd_code,
    .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_error, .strap_vout_ceiling, .hl_shorter, .hl_longer,
    .lh_shorter, .lh_longer, .novl_hl_ns, .novl_lh_ns, .hl_gap, .hl_overlap, .lh_gap,
    .lh_overlap, .hl_adaptive, .lh_adaptive, .prev_rail_en, .prev_rail_group_id,
    .next_rail_en, .next_rail_group_id, .sense_tempco_factor);
  pnr_host_model host (.core_clk, .cmd_valid, .cmd_write, .cmd_is_word, .cmd_code,
    .cmd_wdata, .cmd_ack, .cmd_error, .cmd_rdata);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    logic ok;
    host.xfer(w, c, d, ok, er, rd);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR cmd_ack expected 1 seen %0b", ok);
      report_and_stop();
    end
  endtask

  task automatic steer(input logic a, input logic b, input logic x, input logic y);
    {hl_shorter, hl_longer, lh_shorter, lh_longer} = {a, b, x, y};
    repeat (40) @(posedge core_clk);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    strap_vout_ceiling = 16'h1234;
    {hl_shorter, hl_longer, lh_shorter, lh_longer} = 4'h0;
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    `CHK("hl_start", 8'h3C, novl_hl_ns)
    for (int i = 0; i < 6; i++) begin
      cmd(1'b0, rc[i], 16'h0000);
      `CHK("reset_value", rv[i], rd)
    end
    cmd(1'b1, CMD_EXT_TEMP_GAIN, 16'hA5C3);
    `CHK("gain_wr", 1'b0, er)
    cmd(1'b0, CMD_EXT_TEMP_GAIN, 16'h0000);
    `CHK("gain", 16'hA5C3, rd)
    cmd(1'b1, CMD_EXT_TEMP_BIAS, 16'h5A3C);
    cmd(1'b0, CMD_EXT_TEMP_BIAS, 16'h0000);
    `CHK("bias", 16'h5A3C, rd)
    cmd(1'b1, CMD_SENSE_TEMPCO, 16'hFF7E);
    cmd(1'b0, CMD_SENSE_TEMPCO, 16'h0000);
    `CHK("tempco", 16'h007E, rd)
    `CHK("tempco_out", 8'h7E, sense_tempco_factor)
    cmd(1'b1, CMD_OUTPUT_CEILING, 16'h0001);
    `CHK("ceiling_wr", 1'b1, er)
    cmd(1'b0, CMD_OUTPUT_CEILING, 16'h0000);
    `CHK("ceiling", 16'h1234, rd)
    cmd(1'b1, CMD_RAIL_ORDER, 16'h9F85);
    `CHK("prev_on", 6'h3F, {prev_rail_en, prev_rail_group_id})
    `CHK("next_on", 6'h25, {next_rail_en, next_rail_group_id})
    cmd(1'b1, CMD_RAIL_ORDER, 16'h0A1F);
    `CHK("prev_off", 6'h0A, {prev_rail_en, prev_rail_group_id})
    `CHK("next_off", 6'h1F, {next_rail_en, next_rail_group_id})
    cmd(1'b1, CMD_NOVL_VALUES, 16'h3D00);
    `CHK("hl_range", 1'b1, er)
    cmd(1'b1, CMD_NOVL_VALUES, 16'h00F5);
    `CHK("lh_range", 1'b1, er)
    cmd(1'b1, CMD_NOVL_VALUES, 16'h1EF6);
    cmd(1'b1, CMD_NOVL_MODE, 16'h8080);
    @(posedge core_clk);
    #1;
    `CHK("adaptive", 2'b00, {hl_adaptive, lh_adaptive})
    `CHK("hl_frozen", 8'h1E, novl_hl_ns)
    `CHK("lh_frozen", 8'hF6, novl_lh_ns)
    `CHK("sign", 4'b1001, {hl_gap, hl_overlap, lh_gap, lh_overlap})
    cmd(1'b1, CMD_NOVL_VALUES, 16'h1414);
    cmd(1'b1, CMD_NOVL_MODE, 16'h0505);
    steer(1'b0, 1'b1, 1'b1, 1'b0);
    `CHK("hl_max", 8'h14, novl_hl_ns)
    `CHK("lh_min", 8'h0A, novl_lh_ns)
    steer(1'b1, 1'b0, 1'b0, 1'b1);
    `CHK("hl_min", 8'h0A, novl_hl_ns)
    `CHK("lh_max", 8'h14, novl_lh_ns)
    cmd(1'b1, CMD_NOVL_VALUES, 16'h3232);
    cmd(1'b0, CMD_RAIL_ORDER, 16'h0000);
    cmd(1'b1, CMD_NOVL_MODE, 16'h0505);
    steer(1'b0, 1'b1, 1'b0, 1'b1);
    `CHK("adaptive_on", 2'b11, {hl_adaptive, lh_adaptive})
    `CHK("hl_kept_max", 8'h14, novl_hl_ns)
    `CHK("lh_kept_max", 8'h14, novl_lh_ns)
    report_and_stop();
  end
endmodule
